// ==== core/eeprom_slave_pkg.sv ====
package eeprom_slave_pkg;

	localparam int unsigned CLK_PERIOD_NS  = 8;
	localparam int unsigned GLITCH_NS      = 50;
	localparam int unsigned OUT_DELAY_NS   = 300;
	localparam int unsigned PROG_TIME_MS   = 5;
	localparam int unsigned NS_PER_MS      = 1000000;

	// Spikes up to the reject width are never accepted; round up past it.
	localparam int unsigned GLITCH_CYCLES    = (GLITCH_NS + CLK_PERIOD_NS) / CLK_PERIOD_NS;
	localparam int unsigned OUT_DELAY_CYCLES = (OUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PROG_CYCLES_DEF  = (PROG_TIME_MS * NS_PER_MS) / CLK_PERIOD_NS;

	localparam int unsigned BYTE_BITS    = 8;
	localparam int unsigned ADDR_BITS    = 12;
	localparam int unsigned ADDR_HI_BITS = ADDR_BITS - BYTE_BITS;
	localparam int unsigned CACHE_BITS   = 6;
	localparam int unsigned PAGE_BITS    = 3;
	localparam int unsigned CACHE_PAGES  = 8;

	localparam int unsigned CTRL_RW_BIT   = 0;
	localparam int unsigned CTRL_SEL_LSB  = 1;
	localparam int unsigned CTRL_TYPE_LSB = 4;

	// Value is arbitrary.
	localparam logic [3:0] TYPE_CODE_DEF = 4'h5;

	localparam logic [3:0] BIT_CNT_LAST = 4'h7;
	localparam logic [3:0] BIT_CNT_FULL = 4'h8;

	typedef struct packed {
		logic [ADDR_BITS-1:0] addr;
		logic [BYTE_BITS-1:0] data;
	} mem_wr_s;

	typedef struct packed {
		logic scl;
		logic sda;
	} bus_pins_s;

	typedef enum logic [2:0] {
		st_idle,
		st_rx,
		st_rx_ack,
		st_tx,
		st_tx_ack
	} link_state_e;

	typedef enum logic [1:0] {
		k_ctrl,
		k_addr_hi,
		k_addr_lo,
		k_data
	} byte_kind_e;

endpackage : eeprom_slave_pkg

// ==== core/eeprom_two_wire_slave_port.sv ====
`timescale 1ns/1ps
`default_nettype none

module eeprom_two_wire_slave_port
	import eeprom_slave_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF,
	parameter logic [3:0]  TYPE_CODE   = TYPE_CODE_DEF
) (
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	input  wire logic                 scl_i,
	input  wire logic                 sda_i,
	output logic                      sda_o,
	output logic                      sda_oe,
	input  wire logic                 select_strap_bit0,
	input  wire logic                 select_strap_bit1,
	input  wire logic                 select_strap_bit2,
	output mem_wr_s                   wr_o,
	output logic                      wr_valid,
	output logic [ADDR_BITS-1:0]      rd_addr,
	input  wire logic [BYTE_BITS-1:0] rd_data,
	output logic                      prog_start,
	output logic                      prog_busy
);

	localparam int unsigned PCW = $clog2(PROG_CYCLES + 1);
	localparam int unsigned DCW = $clog2(OUT_DELAY_CYCLES + 1);
	localparam int unsigned NPW = $clog2(CACHE_PAGES + 1);

	generate
		if (PROG_CYCLES < 1 || OUT_DELAY_CYCLES < 1) begin : g_bad
			$error("program and output delay counts must be at least one cycle");
		end
	endgenerate

	bus_pins_s pins;
	logic      scl_f;
	logic      sda_f;
	logic      scl_q;
	logic      sda_q;
	logic      start_ev;
	logic      stop_ev;
	logic      scl_rise;
	logic      scl_fall;
	logic      sel_match;
	logic [2:0] straps_q;

	pin_filter #(.HOLD_CYCLES(GLITCH_CYCLES)) u_scl_filter (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.pin_i   (scl_i),
		.level_o (scl_f)
	);

	pin_filter #(.HOLD_CYCLES(GLITCH_CYCLES)) u_sda_filter (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.pin_i   (sda_i),
		.level_o (sda_f)
	);

	// Filtered pin levels travel together, each from its own filter.
	assign pins = '{scl: scl_f, sda: sda_f};

	// The straps are static; sampling them each cycle replaces the zero that reset loads.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			straps_q <= 3'h0;
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
		end else begin
			straps_q <= {select_strap_bit2, select_strap_bit1, select_strap_bit0};
			scl_q    <= pins.scl;
			sda_q    <= pins.sda;
		end
	end

	assign start_ev = scl_q && pins.scl && sda_q && !pins.sda;
	assign stop_ev  = scl_q && pins.scl && !sda_q && pins.sda;
	assign scl_rise = !scl_q && pins.scl;
	assign scl_fall = scl_q && !pins.scl;

	function automatic logic ctrl_match(input logic [BYTE_BITS-1:0] b, input logic [2:0] s);
		ctrl_match = (b[BYTE_BITS-1:CTRL_TYPE_LSB] == TYPE_CODE)
			&& (b[CTRL_TYPE_LSB-1:CTRL_SEL_LSB] == s);
	endfunction : ctrl_match

	link_state_e          state_q;
	link_state_e          state_d;
	byte_kind_e           kind_q;
	byte_kind_e           kind_d;
	logic [3:0]           cnt_q;
	logic [3:0]           cnt_d;
	logic [BYTE_BITS-1:0] shift_q;
	logic [BYTE_BITS-1:0] shift_d;
	logic [BYTE_BITS-1:0] tx_q;
	logic [BYTE_BITS-1:0] tx_d;
	logic [ADDR_BITS-1:0] addr_q;
	logic [ADDR_BITS-1:0] addr_d;
	logic                 rd_q;
	logic                 rd_d;
	logic                 want_q;
	logic                 want_d;
	logic                 pull_q;
	logic                 pull_d;
	logic [DCW-1:0]       dly_q;
	logic [DCW-1:0]       dly_d;
	logic                 dirty_q;
	logic                 dirty_d;
	logic [NPW-1:0]       pages_q;
	logic [NPW-1:0]       pages_d;
	logic [NPW-1:0]       prog_pages_q;
	logic [NPW-1:0]       prog_pages_d;
	logic [PCW-1:0]       prog_cyc_q;
	logic [PCW-1:0]       prog_cyc_d;
	mem_wr_s              wr_q;
	mem_wr_s              wr_d;
	logic                 wr_valid_q;
	logic                 wr_valid_d;
	logic                 prog_start_q;
	logic                 prog_start_d;
	logic                 busy;

	assign busy      = (prog_pages_q != '0);
	assign sel_match = ctrl_match(shift_q, straps_q);

	always_comb begin
		state_d      = state_q;
		kind_d       = kind_q;
		cnt_d        = cnt_q;
		shift_d      = shift_q;
		tx_d         = tx_q;
		addr_d       = addr_q;
		rd_d         = rd_q;
		want_d       = want_q;
		pull_d       = pull_q;
		dly_d        = dly_q;
		dirty_d      = dirty_q;
		pages_d      = pages_q;
		prog_pages_d = prog_pages_q;
		prog_cyc_d   = prog_cyc_q;
		wr_d         = wr_q;
		wr_valid_d   = 1'b0;
		prog_start_d = 1'b0;

		// Self-timed program cycle, one period per cached page.
		if (busy) begin
			if (prog_cyc_q == PCW'(1)) begin
				prog_cyc_d   = PCW'(PROG_CYCLES);
				prog_pages_d = prog_pages_q - NPW'(1);
			end else begin
				prog_cyc_d = prog_cyc_q - PCW'(1);
			end
		end

		// Line changes wait out the delay after the clock falls.
		if (dly_q != '0) begin
			dly_d = dly_q - DCW'(1);
			if (dly_q == DCW'(1)) begin
				pull_d = want_q;
			end
		end

		if (start_ev) begin
			// The master opens every command; the device never does.
			state_d = st_rx;
			kind_d  = k_ctrl;
			cnt_d   = 4'h0;
			want_d  = 1'b0;
			pull_d  = 1'b0;
			dly_d   = '0;
		end else if (stop_ev) begin
			state_d = st_idle;
			want_d  = 1'b0;
			pull_d  = 1'b0;
			dly_d   = '0;
			if (dirty_q) begin
				prog_pages_d = pages_q;
				prog_cyc_d   = PCW'(PROG_CYCLES);
				prog_start_d = 1'b1;
			end
			dirty_d = 1'b0;
			pages_d = '0;
		end else begin
			unique case (state_q)
				st_idle: begin
					// Only a START or a STOP is acted on until the next START.
					state_d = st_idle;
				end
				st_rx: begin
					if (scl_rise && cnt_q != BIT_CNT_FULL) begin
						shift_d = {shift_q[BYTE_BITS-2:0], pins.sda};
						cnt_d   = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == BIT_CNT_FULL) begin
						if (busy || (kind_q == k_ctrl && !sel_match)) begin
							state_d = st_idle;
						end else begin
							state_d = st_rx_ack;
							want_d  = 1'b1;
							dly_d   = DCW'(OUT_DELAY_CYCLES);
							unique case (kind_q)
								k_ctrl: begin
									rd_d   = shift_q[CTRL_RW_BIT];
									kind_d = shift_q[CTRL_RW_BIT] ? k_data : k_addr_hi;
								end
								k_addr_hi: begin
									addr_d[ADDR_BITS-1:BYTE_BITS] = shift_q[ADDR_HI_BITS-1:0];
									kind_d = k_addr_lo;
								end
								k_addr_lo: begin
									addr_d[BYTE_BITS-1:0] = shift_q;
									kind_d = k_data;
								end
								k_data: begin
									// The stream runs on with no count limit.
									wr_d       = '{addr: addr_q, data: shift_q};
									wr_valid_d = 1'b1;
									dirty_d    = 1'b1;
									addr_d[CACHE_BITS-1:0] = addr_q[CACHE_BITS-1:0] + CACHE_BITS'(1);
									if ((!dirty_q || addr_q[PAGE_BITS-1:0] == '0) && pages_q != NPW'(CACHE_PAGES)) begin
										pages_d = pages_q + NPW'(1);
									end
								end
							endcase
						end
					end
				end
				st_rx_ack: begin
					if (scl_fall) begin
						dly_d = DCW'(OUT_DELAY_CYCLES);
						cnt_d = 4'h0;
						if (rd_q) begin
							state_d = st_tx;
							tx_d    = rd_data;
							want_d  = !rd_data[BYTE_BITS-1];
							addr_d  = addr_q + ADDR_BITS'(1);
						end else begin
							state_d = st_rx;
							want_d  = 1'b0;
						end
					end
				end
				st_tx: begin
					if (scl_fall) begin
						dly_d = DCW'(OUT_DELAY_CYCLES);
						if (cnt_q == BIT_CNT_LAST) begin
							state_d = st_tx_ack;
							want_d  = 1'b0;
						end else begin
							cnt_d  = cnt_q + 4'h1;
							tx_d   = {tx_q[BYTE_BITS-2:0], 1'b0};
							want_d = !tx_q[BYTE_BITS-2];
						end
					end
				end
				st_tx_ack: begin
					if (scl_rise && pins.sda) begin
						state_d = st_idle;
					end else if (scl_fall) begin
						state_d = st_tx;
						cnt_d   = 4'h0;
						tx_d    = rd_data;
						want_d  = !rd_data[BYTE_BITS-1];
						dly_d   = DCW'(OUT_DELAY_CYCLES);
						addr_d  = addr_q + ADDR_BITS'(1);
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q      <= st_idle;
			kind_q       <= k_ctrl;
			cnt_q        <= 4'h0;
			shift_q      <= '0;
			tx_q         <= '0;
			addr_q       <= '0;
			rd_q         <= 1'b0;
			want_q       <= 1'b0;
			pull_q       <= 1'b0;
			dly_q        <= '0;
			dirty_q      <= 1'b0;
			pages_q      <= '0;
			prog_pages_q <= '0;
			prog_cyc_q   <= '0;
			wr_q         <= '0;
			wr_valid_q   <= 1'b0;
			prog_start_q <= 1'b0;
		end else begin
			state_q      <= state_d;
			kind_q       <= kind_d;
			cnt_q        <= cnt_d;
			shift_q      <= shift_d;
			tx_q         <= tx_d;
			addr_q       <= addr_d;
			rd_q         <= rd_d;
			want_q       <= want_d;
			pull_q       <= pull_d;
			dly_q        <= dly_d;
			dirty_q      <= dirty_d;
			pages_q      <= pages_d;
			prog_pages_q <= prog_pages_d;
			prog_cyc_q   <= prog_cyc_d;
			wr_q         <= wr_d;
			wr_valid_q   <= wr_valid_d;
			prog_start_q <= prog_start_d;
		end
	end

	// Open-drain data: the device only ever pulls low.
	assign sda_o      = 1'b0;
	assign sda_oe     = pull_q;
	assign wr_o       = wr_q;
	assign wr_valid   = wr_valid_q;
	assign rd_addr    = addr_q;
	assign prog_start = prog_start_q;
	assign prog_busy  = busy;

endmodule : eeprom_two_wire_slave_port

`default_nettype wire

// ==== core/pin_filter.sv ====
`timescale 1ns/1ps
`default_nettype none

module pin_filter
	import eeprom_slave_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = GLITCH_CYCLES
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic pin_i,
	output logic      level_o
);

	localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);

	generate
		if (HOLD_CYCLES < 1) begin : g_bad
			$error("pin_filter needs a hold of at least one cycle");
		end
	endgenerate

	logic [2:0]    sync_q;
	logic [2:0]    sync_d;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          level_q;
	logic          level_d;

	always_comb begin
		sync_d  = {sync_q[1:0], pin_i};
		cnt_d   = '0;
		level_d = level_q;
		// A change counts only while the second and third stage agree and hold long enough.
		if (sync_q[1] == sync_q[2] && sync_q[2] != level_q) begin
			if (cnt_q == CW'(HOLD_CYCLES - 1)) begin
				level_d = sync_q[2];
			end else begin
				cnt_d = cnt_q + CW'(1);
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync_q  <= 3'h7;
			cnt_q   <= '0;
			level_q <= 1'b1;
		end else begin
			sync_q  <= sync_d;
			cnt_q   <= cnt_d;
			level_q <= level_d;
		end
	end

	assign level_o = level_q;

endmodule : pin_filter

`default_nettype wire

// ==== tb/eeprom_two_wire_slave_port_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module eeprom_two_wire_slave_port_bench
	import eeprom_slave_pkg::*;
;
	localparam int unsigned PROG = 3000;
	localparam logic [7:0]  CW   = {TYPE_CODE_DEF, 3'h5, 1'b0};

	logic                 mclk;
	logic                 rst_n;
	logic                 scl;
	logic                 m_oe;
	logic                 sda_o;
	logic                 sda_oe;
	logic [2:0]           strap;
	mem_wr_s              wr_o;
	mem_wr_s              wr_last;
	logic                 wr_valid;
	logic                 prog_start;
	logic                 prog_busy;
	logic [ADDR_BITS-1:0] rd_addr;
	logic [BYTE_BITS-1:0] rd_data;
	logic [8:0]           r;
	logic [7:0]           bad [2];
	wire logic            sda;
	int                   err_count = 0;
	int                   n_checks = 0;
	int                   wr_n = 0;
	int                   ps_n = 0;
	int                   busy_n = 0;
	int                   k;

	assign sda     = !((sda_oe && !sda_o) || m_oe);
	assign rd_data = rd_addr[7:0] ^ 8'h3c;

	eeprom_two_wire_slave_port #(.PROG_CYCLES(PROG)) u_eeprom_two_wire_slave_port (
		.mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.select_strap_bit0(strap[0]), .select_strap_bit1(strap[1]), .select_strap_bit2(strap[2]),
		.wr_o(wr_o), .wr_valid(wr_valid), .rd_addr(rd_addr), .rd_data(rd_data),
		.prog_start(prog_start), .prog_busy(prog_busy)
	);

	two_wire_master u_two_wire_master (.mclk(mclk), .sda(sda), .scl(scl), .m_oe(m_oe));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		if (wr_valid === 1'b1) begin
			wr_n    <= wr_n + 1;
			wr_last <= wr_o;
		end
		if (prog_start === 1'b1) ps_n <= ps_n + 1;
		if (prog_busy === 1'b1) busy_n <= busy_n + 1;
	end

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run;
		$display("errors=%0d checks=%0d", err_count, n_checks);
		if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : complete_run

	// Sends a byte with the line released for the acknowledge and checks its level.
	task automatic send(input logic [7:0] b, input logic nak);
		u_two_wire_master.xfer({b, 1'b1}, r);
		check(r[0], nak);
	endtask : send

	initial begin
		rst_n  = 1'b0;
		strap  = 3'h5;
		bad[0] = {TYPE_CODE_DEF ^ 4'h1, 3'h5, 1'b0};
		bad[1] = {TYPE_CODE_DEF, 3'h2, 1'b1};
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (20) @(posedge mclk);
		u_two_wire_master.start();
		send(CW, 1'b0);
		send(8'h01, 1'b0);
		send(8'h07, 1'b0);
		send(8'ha1, 1'b0);
		send(8'hb2, 1'b0);
		u_two_wire_master.stop();
		check(wr_n, 2);
		check(wr_last, {12'h108, 8'hb2});
		u_two_wire_master.start();
		send(CW, 1'b1);
		u_two_wire_master.stop();
		k = 0;
		while (prog_busy !== 1'b0 && k < 20000) begin
			@(posedge mclk);
			k++;
		end
		if (k == 20000) begin
			err_count++;
			complete_run();
		end
		check(ps_n, 1);
		check(busy_n, 2 * PROG);
		foreach (bad[j]) begin
			u_two_wire_master.start();
			send(bad[j], 1'b1);
			send(CW, 1'b1);
			u_two_wire_master.stop();
		end
		u_two_wire_master.start();
		send({CW[7:1], 1'b1}, 1'b0);
		u_two_wire_master.xfer(9'h1fe, r);
		check(r[8:1], 8'h09 ^ 8'h3c);
		u_two_wire_master.xfer(9'h1ff, r);
		check(r, {8'h0a ^ 8'h3c, 1'b1});
		u_two_wire_master.stop();
		check(sda, 1'b1);
		check(wr_n, 2);
		u_two_wire_master.start();
		u_two_wire_master.clock_spike(3);
		send(CW, 1'b0);
		u_two_wire_master.stop();
		complete_run();
	end
endmodule : eeprom_two_wire_slave_port_bench

bind eeprom_two_wire_slave_port slave_port_props #(.PROG_CYCLES(PROG_CYCLES)) u_slave_port_props (
	.mclk(mclk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
	.select_strap_bit0(select_strap_bit0), .select_strap_bit1(select_strap_bit1),
	.select_strap_bit2(select_strap_bit2), .wr_o(wr_o), .wr_valid(wr_valid), .rd_addr(rd_addr),
	.rd_data(rd_data), .prog_start(prog_start), .prog_busy(prog_busy)
);

`default_nettype wire

// ==== tb/slave_port_props.sv ====
`timescale 1ns/1ps
`default_nettype none

module slave_port_props
	import eeprom_slave_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
	input wire logic                 mclk,
	input wire logic                 rst_n,
	input wire logic                 scl_i,
	input wire logic                 sda_i,
	input wire logic                 sda_o,
	input wire logic                 sda_oe,
	input wire logic                 select_strap_bit0,
	input wire logic                 select_strap_bit1,
	input wire logic                 select_strap_bit2,
	input wire mem_wr_s              wr_o,
	input wire logic                 wr_valid,
	input wire logic [ADDR_BITS-1:0] rd_addr,
	input wire logic [BYTE_BITS-1:0] rd_data,
	input wire logic                 prog_start,
	input wire logic                 prog_busy
);
	logic [7:0]  low_q;
	int unsigned busy_q;

	// Counts clock-low cycles at the pin and the length of a program cycle.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			low_q  <= 8'h00;
			busy_q <= 0;
		end else begin
			low_q  <= scl_i ? 8'h00 : low_q + {7'h00, low_q != 8'hff};
			busy_q <= prog_busy ? busy_q + 1 : 0;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_ack_hold: assert property (scl_i && sda_oe |=> sda_oe || !scl_i)
		else $error("data line released while clock high");
	a_out_delay: assert property ($rose(sda_oe) |-> low_q >= 8'd38)
		else $error("data driven too soon after clock fall");
	a_busy_nack: assert property (prog_busy |-> !$rose(sda_oe))
		else $error("line driven while programming");
	a_stop_seen: assert property (prog_start |-> scl_i && sda_i)
		else $error("program start without stop");
	a_prog_pulse: assert property (prog_start |-> prog_busy ##1 (prog_busy && !prog_start))
		else $error("program start pulse malformed");
	a_busy_len: assert property ($fell(prog_busy) |-> busy_q % PROG_CYCLES == 0 && busy_q <= 8 * PROG_CYCLES)
		else $error("program cycle length wrong");
	a_wr_slot: assert property (wr_valid |-> !scl_i && !prog_busy)
		else $error("write outside a clock-low slot");
	a_pull_low: assert property (sda_oe |-> !sda_o)
		else $error("driven data not low");
endmodule : slave_port_props

`default_nettype wire

// ==== tb/two_wire_master.sv ====
`timescale 1ns/1ps
`default_nettype none

module two_wire_master (
	input  wire logic mclk,
	input  wire logic sda,
	output logic      scl,
	output logic      m_oe
);
	initial begin
		scl  = 1'b1;
		m_oe = 1'b0;
	end

	task automatic q;
		repeat (50) @(posedge mclk);
	endtask : q

	// Master owns the clock and opens commands from a released line.
	task automatic start;
		m_oe <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		m_oe <= 1'b1;
		q();
		scl <= 1'b0;
		q();
	endtask : start

	task automatic stop;
		m_oe <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		m_oe <= 1'b0;
		q();
		q();
	endtask : stop

	// A clock pulse shorter than the reject width, as noise would make.
	task automatic clock_spike(input int unsigned n);
		scl <= 1'b1;
		repeat (n) @(posedge mclk);
		scl <= 1'b0;
		q();
	endtask : clock_spike

	// Nine bits, data changed only with clock low, ninth is acknowledge.
	task automatic xfer(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			m_oe <= !d[i];
			q();
			scl <= 1'b1;
			q();
			r[i] = sda;
			q();
			scl <= 1'b0;
			q();
		end
	endtask : xfer
endmodule : two_wire_master

`default_nettype wire
